// *** logic/lam_pkg.sv ***
// Constants, field layout and carrier types for the line alarm status monitor.
// Assumes a 40 MHz system clock and a receive line clock from the line interface.
`default_nettype none

package lam_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 9;
   localparam logic [8:0] RX_ALARM_OFS = 9'h047;
   localparam logic [8:0] TX_ALARM_OFS = 9'h048;

   localparam int RX_HOLD_BIT = 0;
   localparam int RX_FRAME_BIT = 1;
   localparam int RX_SIGNAL_BIT = 2;
   localparam int RX_COMBINED_BIT = 3;
   localparam int RX_AIS_BIT = 4;
   localparam int TX_FRAME_BIT = 1;
   localparam int TX_CLOCK_BIT = 3;
   localparam int TX_REQUEST_BIT = 6;
   localparam int TX_RELEASE_BIT = 7;

   // ----------------------------------------
   // Receive line criteria, in bits
   // ----------------------------------------
   localparam logic [6:0] ZERO_RUN_T1 = 7'h64;
   localparam logic [6:0] ZERO_RUN_E1 = 7'h20;
   localparam logic [7:0] CLEAR_WIN_T1 = 8'h72;
   localparam logic [7:0] CLEAR_WIN_E1 = 8'hc1;
   localparam logic [7:0] T1_MIN_ONES = 8'h0f;
   localparam logic [12:0] AIS_WIN_T1 = 13'h1218;
   localparam logic [12:0] AIS_WIN_E1 = 13'h0200;
   localparam logic [2:0] AIS_LOW_T1 = 3'h4;
   localparam logic [2:0] AIS_LOW_E1 = 3'h2;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_KHZ = 40000;
   localparam int LOSS_HOLD_US = 1000;
   localparam int LOSS_HOLD_CYC = (LOSS_HOLD_US * CLK_KHZ) / 1000;
   localparam int SIG_HOLD_MS = 9;
   localparam int SIG_HOLD_CYC = SIG_HOLD_MS * CLK_KHZ;
   localparam int FRAME_INTEG_CYC = 4000;
   localparam logic [5:0] RX_CLK_TIMEOUT = 6'h3f;
   localparam logic [2:0] TX_REF_WIN = 3'h7;
   localparam logic [2:0] TX_PRESENT_MIN = 3'h4;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic e1_mode;
      logic combined_loss_select;
      logic frame_loss_integration;
      logic ais_clock_switch;
      logic hold_force_on;
      logic hold_force_off;
   } lam_cfg_t;

   typedef struct packed {
      logic basic_align_lost;
      logic multiframe_align_lost;
      logic cas_align_lost;
      logic align_change_event;
   } lam_align_t;

   typedef struct packed {
      logic tx_frame_lost;
      logic loop_request_detect;
      logic loop_release_detect;
   } lam_tx_in_t;

endpackage

`default_nettype wire

// *** logic/lam_monitor.sv ***
// Receive and transmit alarm monitor with its two read-only status registers.
// Assumes receive data arrives on the line clock; all else is on clk.
//
// Behaviour
// (RL1) E1: clear all-ones alarm on two double frames with 3+ zeros or alignment regained.
// (RL2) E1: set all-ones alarm on two double frames with 2 or fewer zeros, alignment lost.
// (RL3) T1: clear all-ones alarm on 3 ms with 5+ zeros or alignment regained.
// (RL4) T1: set all-ones alarm on 3 ms with 4 or fewer zeros and alignment lost.
// (RL5) Clock mode: combined loss is 1 without receive line clock, 0 with it.
// (RL6) Signal mode: combined loss follows signal loss held continuously for 1 ms.
// (RL7) T1: signal loss set after 100 consecutive zeros.
// (RL8) T1: signal loss cleared by 12.5% ones over 114 bits from a pulse.
// (RL9) E1: signal loss set after 32 consecutive zeros.
// (RL10) E1: signal loss cleared by 193 bits from a pulse without 32 zeros.
// (RL11) Frame loss is real-time or integrated per mode and integration setting.
// (RL12) E1: frame loss is OR of basic, multiframe and CAS alignment losses.
// (RL13) While held, signaling buffer updates stop and outputs keep buffered values.
// (RL14) Signaling hold lasts 6 to 12 ms after alignment change or frame loss.
// (RL15) Signaling hold follows manual force-on and force-off controls.
// (RL16) A change of any transmit status bit pulses its interrupt status bit.
// (RL17) Software writes zero to reserved transmit status bits.
// (RL18) Bit 7 of transmit status shows loop-release code detected.
// (RL19) Bit 6 of transmit status shows loop-request code detected.
// (RL20) Transmit clock lost on no edges in 8 ref cycles, present on 4+.
// (RL21) Clock-lost with AIS switch shows clock in use and forced AIS.
// (RL22) Transmit frame-loss bit shows the transmit framer alignment state.
// (RL23) A change of any receive status bit pulses its interrupt status bit.
// (RL24) Both status registers are read-only; writes have no effect.
`timescale 1ns/10ps
`default_nettype none

module lam_monitor #(
   parameter int LOSS_HOLD_CYC = lam_pkg::LOSS_HOLD_CYC,
   parameter int SIG_HOLD_CYC = lam_pkg::SIG_HOLD_CYC,
   parameter int FRAME_INTEG_CYC = lam_pkg::FRAME_INTEG_CYC
) (
   // System clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Receive line from the line interface
   input wire logic rx_line_clock,
   input wire logic rx_data,
   // Configuration and framer inputs
   input wire lam_pkg::lam_cfg_t cfg,
   input wire lam_pkg::lam_align_t align,
   input wire lam_pkg::lam_tx_in_t tx_in,
   // Transmit clock pins
   input wire logic tx_line_clock,
   input wire logic ref_clock_1544,
   input wire logic ref_clock_2048,
   // Register read port
   input wire logic [lam_pkg::ADDR_W-1:0] addr,
   input wire logic rd_en,
   output logic [7:0] rdata,
   // Change pulses towards the interrupt status registers
   output logic [7:0] irq_status_rx_alarms,
   output logic [7:0] irq_status_tx_alarms,
   // Signaling buffer and transmit clock control
   output logic rx_signaling_update_en,
   output logic tx_ref_clock_in_use,
   output logic tx_ais_forced
);

   // ----------------------------------------
   // Receive line domain
   // ----------------------------------------
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic mode_s1;
      logic mode_s2;
      logic tog;
      logic [6:0] zrun;
      logic rx_signal_loss;
      logic cwin;
      logic [7:0] ccnt;
      logic [7:0] ones;
      logic [12:0] awin;
      logic [2:0] azero;
      logic prev_low;
      logic dens_low;
      logic dens_ok;
   } lam_rx_state_t;

   lam_rx_state_t rq;
   lam_rx_state_t rd;

   function automatic logic [6:0] zero_run_limit(input logic e1);
      zero_run_limit = e1 ? lam_pkg::ZERO_RUN_E1 : lam_pkg::ZERO_RUN_T1;
   endfunction

   always_comb begin
      logic [6:0] zlim;
      logic [7:0] cwin_len;
      logic [7:0] ones_n;
      logic [12:0] awin_len;
      logic [2:0] zeros_n;
      logic low;
      zlim = zero_run_limit(rq.mode_s2);
      cwin_len = rq.mode_s2 ? lam_pkg::CLEAR_WIN_E1 : lam_pkg::CLEAR_WIN_T1;
      ones_n = rq.ones + {7'h00, rx_data};
      awin_len = rq.mode_s2 ? lam_pkg::AIS_WIN_E1 : lam_pkg::AIS_WIN_T1;
      zeros_n = (rq.azero == 3'h7 || rx_data) ? rq.azero : rq.azero + 3'h1;
      low = 1'b0;
      rd = rq;
      rd.rst_s1 = resetn;
      rd.rst_s2 = rq.rst_s1;
      rd.mode_s1 = cfg.e1_mode;
      rd.mode_s2 = rq.mode_s1;
      // Free-running toggle lets clk see whether this clock runs
      rd.tog = ~rq.tog;
      // Zero run, saturating at the mode's limit
      if (rx_data) begin
         rd.zrun = 7'h00;
      end else if (rq.zrun != zlim) begin
         rd.zrun = rq.zrun + 7'h01;
      end
      if (rd.zrun == zlim) begin
         rd.rx_signal_loss = 1'b1; // RL7 RL9
         rd.cwin = 1'b0; // RL8 RL10
      end else if (rq.rx_signal_loss) begin
         if (!rq.cwin) begin
            if (rx_data) begin
               rd.cwin = 1'b1;
               rd.ccnt = 8'h01;
               rd.ones = 8'h01;
            end
         end else begin
            rd.ccnt = rq.ccnt + 8'h01;
            rd.ones = ones_n;
            if (rd.ccnt == cwin_len) begin
               rd.cwin = 1'b0;
               if (rq.mode_s2 || ones_n >= lam_pkg::T1_MIN_ONES) begin
                  rd.rx_signal_loss = 1'b0; // RL8 RL10
               end
            end
         end
      end
      // Zero density per window for the all-ones alarm
      rd.awin = rq.awin + 13'h0001;
      rd.azero = zeros_n;
      // At or past the end, so a mode switch mid-window cannot skip it
      if (rd.awin >= awin_len) begin
         rd.awin = 13'h0000;
         rd.azero = 3'h0;
         if (rq.mode_s2) begin
            low = zeros_n <= lam_pkg::AIS_LOW_E1;
            rd.dens_low = low && rq.prev_low; // RL2
            rd.dens_ok = !low && !rq.prev_low; // RL1
         end else begin
            low = zeros_n <= lam_pkg::AIS_LOW_T1;
            rd.dens_low = low; // RL4
            rd.dens_ok = !low; // RL3
         end
         rd.prev_low = low;
      end
      // Reset comes through two line-clock flops; one edge while low is enough
      if (!rq.rst_s2) begin
         rd = '0;
         rd.rst_s1 = resetn;
         rd.rst_s2 = rq.rst_s1;
      end
   end

   always_ff @(posedge rx_line_clock) begin
      rq <= rd;
   end

   // ----------------------------------------
   // System domain
   // ----------------------------------------
   typedef struct packed {
      logic rx_signal_loss_s1;
      logic rx_signal_loss_s2;
      logic dlow_s1;
      logic dlow_s2;
      logic dok_s1;
      logic dok_s2;
      logic tog_s1;
      logic tog_s2;
      logic tog_d;
      logic [5:0] clk_to;
      logic rx_clk_lost;
      logic [31:0] loss_cnt;
      logic combined;
      logic lof;
      logic [31:0] integ_cnt;
      logic [31:0] hold_cnt;
      logic hold;
      logic ais;
      logic txc_s1;
      logic txc_s2;
      logic txc_d;
      logic [1:0] ref_s1;
      logic [1:0] ref_s2;
      logic ref_d;
      logic [2:0] ref_cnt;
      logic [2:0] tr_cnt;
      logic tx_lost;
      lam_pkg::lam_tx_in_t tx_r;
      logic [7:0] rx_prev;
      logic [7:0] tx_prev;
      logic [7:0] rdata;
      logic [7:0] irq_rx;
      logic [7:0] irq_tx;
      logic update_en;
      logic ref_in_use;
      logic ais_forced;
   } lam_sys_state_t;

   lam_sys_state_t sq;
   lam_sys_state_t sd;

   always_comb begin
      logic [7:0] rx_stat;
      logic [7:0] tx_stat;
      logic lof_raw;
      logic ref_sel;
      logic tr;
      rx_stat = 8'h00;
      tx_stat = 8'h00;
      lof_raw = 1'b0;
      ref_sel = 1'b0;
      tr = 1'b0;
      sd = sq;
      // Level crossings from the line domain
      // Only slow single-bit levels cross, so two flops each are enough
      sd.rx_signal_loss_s1 = rq.rx_signal_loss;
      sd.rx_signal_loss_s2 = sq.rx_signal_loss_s1;
      sd.dlow_s1 = rq.dens_low;
      sd.dlow_s2 = sq.dlow_s1;
      sd.dok_s1 = rq.dens_ok;
      sd.dok_s2 = sq.dok_s1;
      sd.tog_s1 = rq.tog;
      sd.tog_s2 = sq.tog_s1;
      sd.tog_d = sq.tog_s2;
      // Receive clock presence
      if (sq.tog_s2 != sq.tog_d) begin
         sd.clk_to = 6'h00;
         sd.rx_clk_lost = 1'b0; // RL5
      end else if (sq.clk_to == lam_pkg::RX_CLK_TIMEOUT) begin
         sd.rx_clk_lost = 1'b1; // RL5
      end else begin
         sd.clk_to = sq.clk_to + 6'h01;
      end
      // Signal loss must stand unbroken before it counts
      if (!sq.rx_signal_loss_s2) begin
         sd.loss_cnt = '0;
      end else if (sq.loss_cnt != LOSS_HOLD_CYC[31:0]) begin
         sd.loss_cnt = sq.loss_cnt + 32'h1;
      end
      if (cfg.combined_loss_select) begin
         sd.combined = sq.rx_clk_lost; // RL5
      end else begin
         sd.combined = sq.rx_signal_loss_s2 && sq.loss_cnt == LOSS_HOLD_CYC[31:0]; // RL6
      end
      // Frame loss
      lof_raw = cfg.e1_mode ?
         (align.basic_align_lost | align.multiframe_align_lost | align.cas_align_lost) :
         align.basic_align_lost; // RL12
      if (!cfg.frame_loss_integration || lof_raw == sq.lof) begin
         sd.integ_cnt = '0;
         sd.lof = lof_raw; // RL11
      end else if (sq.integ_cnt == FRAME_INTEG_CYC[31:0]) begin
         sd.integ_cnt = '0;
         sd.lof = lof_raw; // RL11
      end else begin
         sd.integ_cnt = sq.integ_cnt + 32'h1;
      end
      // Signaling hold; force-off wins over force-on
      if (align.align_change_event || sq.lof) begin
         sd.hold_cnt = SIG_HOLD_CYC[31:0]; // RL14
      end else if (sq.hold_cnt != '0) begin
         sd.hold_cnt = sq.hold_cnt - 32'h1;
      end
      if (cfg.hold_force_off) begin
         sd.hold = 1'b0; // RL15
      end else if (cfg.hold_force_on) begin
         sd.hold = 1'b1; // RL15
      end else begin
         sd.hold = align.align_change_event || sq.lof || sq.hold_cnt != '0; // RL14
      end
      sd.update_en = !sd.hold; // RL13
      // All-ones alarm; clear is tested only while set, set only while clear
      if (sq.ais) begin
         if (sq.dok_s2 || !align.basic_align_lost) begin
            sd.ais = 1'b0; // RL1 RL3
         end
      end else if (sq.dlow_s2 && align.basic_align_lost) begin
         sd.ais = 1'b1; // RL2 RL4
      end
      // Transmit clock monitor against the selected reference
      // With the reference stopped the clock-lost bit simply keeps its value
      sd.txc_s1 = tx_line_clock;
      sd.txc_s2 = sq.txc_s1;
      sd.txc_d = sq.txc_s2;
      sd.ref_s1 = {ref_clock_2048, ref_clock_1544};
      sd.ref_s2 = sq.ref_s1;
      ref_sel = cfg.e1_mode ? sq.ref_s2[1] : sq.ref_s2[0];
      sd.ref_d = ref_sel;
      tr = sq.txc_s2 != sq.txc_d;
      if (tr && sq.tr_cnt != lam_pkg::TX_PRESENT_MIN) begin
         sd.tr_cnt = sq.tr_cnt + 3'h1;
      end
      if (ref_sel && !sq.ref_d) begin
         sd.ref_cnt = sq.ref_cnt + 3'h1;
         if (sq.ref_cnt == lam_pkg::TX_REF_WIN) begin
            if (sd.tr_cnt == 3'h0) begin
               sd.tx_lost = 1'b1; // RL20
            end else if (sd.tr_cnt >= lam_pkg::TX_PRESENT_MIN) begin
               sd.tx_lost = 1'b0; // RL20
            end
            sd.tr_cnt = 3'h0;
         end
      end
      sd.ref_in_use = sq.tx_lost && cfg.ais_clock_switch; // RL21
      sd.ais_forced = sq.tx_lost && cfg.ais_clock_switch; // RL21
      sd.tx_r = tx_in;
      // Status words and change pulses
      rx_stat = 8'h00;
      rx_stat[lam_pkg::RX_HOLD_BIT] = sq.hold;
      rx_stat[lam_pkg::RX_FRAME_BIT] = sq.lof;
      rx_stat[lam_pkg::RX_SIGNAL_BIT] = sq.rx_signal_loss_s2;
      rx_stat[lam_pkg::RX_COMBINED_BIT] = sq.combined;
      rx_stat[lam_pkg::RX_AIS_BIT] = sq.ais;
      tx_stat = 8'h00; // RL17
      tx_stat[lam_pkg::TX_FRAME_BIT] = sq.tx_r.tx_frame_lost; // RL22
      tx_stat[lam_pkg::TX_CLOCK_BIT] = sq.tx_lost; // RL20
      tx_stat[lam_pkg::TX_REQUEST_BIT] = sq.tx_r.loop_request_detect; // RL19
      tx_stat[lam_pkg::TX_RELEASE_BIT] = sq.tx_r.loop_release_detect; // RL18
      sd.rx_prev = rx_stat;
      sd.tx_prev = tx_stat;
      sd.irq_rx = rx_stat ^ sq.rx_prev; // RL23
      sd.irq_tx = tx_stat ^ sq.tx_prev; // RL16
      // Read port only; there is no write path into status
      if (rd_en) begin
         if (addr == lam_pkg::RX_ALARM_OFS) begin
            sd.rdata = rx_stat; // RL24
         end else if (addr == lam_pkg::TX_ALARM_OFS) begin
            sd.rdata = tx_stat; // RL24
         end else begin
            sd.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sq <= '0;
      end else begin
         sq <= sd;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata = sq.rdata;
   assign irq_status_rx_alarms = sq.irq_rx;
   assign irq_status_tx_alarms = sq.irq_tx;
   assign rx_signaling_update_en = sq.update_en;
   assign tx_ref_clock_in_use = sq.ref_in_use;
   assign tx_ais_forced = sq.ais_forced;

endmodule

`default_nettype wire

// *** testbench/lam_chk_monitor.sv ***
// Port checker for the line alarm status monitor.
// Assumes it is bound onto lam_monitor; every check runs on clk.
`timescale 1ns/10ps
`default_nettype none
module lam_chk (
   // Clocks and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_line_clock,
   // Inputs
   input wire lam_pkg::lam_cfg_t cfg,
   input wire lam_pkg::lam_align_t align,
   input wire lam_pkg::lam_tx_in_t tx_in,
   input wire logic [lam_pkg::ADDR_W-1:0] addr,
   input wire logic rd_en,
   // Outputs
   input wire logic [7:0] rdata,
   input wire logic [7:0] irq_status_rx_alarms,
   input wire logic [7:0] irq_status_tx_alarms,
   input wire logic rx_signaling_update_en,
   input wire logic tx_ref_clock_in_use,
   input wire logic tx_ais_forced
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----
   // Sequences
   // ----
   sequence s_e1_loss;
      cfg.e1_mode && !cfg.frame_loss_integration && $rose(align.basic_align_lost
         | align.multiframe_align_lost | align.cas_align_lost);
   endsequence
   sequence s_forced_on;
      (cfg.hold_force_on && !cfg.hold_force_off) [*3];
   endsequence
   // ----
   // Assertions
   // ----
   req_irq_a:
      assert property ($changed(tx_in.loop_request_detect) |-> ##[1:3] irq_status_tx_alarms[6])
      else $error("loop request change without pulse");
   rel_irq_a:
      assert property ($changed(tx_in.loop_release_detect) |-> ##[1:3] irq_status_tx_alarms[7])
      else $error("loop release change without pulse");
   tx_lof_irq_a:
      assert property ($changed(tx_in.tx_frame_lost) |-> ##[1:3] irq_status_tx_alarms[1])
      else $error("tx frame loss change without pulse");
   e1_lof_irq_a:
      assert property (s_e1_loss |-> ##[1:3] irq_status_rx_alarms[1])
      else $error("e1 frame loss without pulse");
   forced_hold_a:
      assert property (s_forced_on |-> !rx_signaling_update_en)
      else $error("buffer updates during forced hold");
   forced_free_a:
      assert property (cfg.hold_force_off [*3] |-> rx_signaling_update_en)
      else $error("buffer updates stopped despite force off");
   ais_pair_a:
      assert property (tx_ais_forced == tx_ref_clock_in_use)
      else $error("clock in use and ais forced differ");
   ais_gate_a:
      assert property ((!cfg.ais_clock_switch) [*2] |-> !tx_ais_forced)
      else $error("ais forced without switch");
   unmapped_zero_a:
      assert property (rd_en && addr != lam_pkg::RX_ALARM_OFS && addr != lam_pkg::TX_ALARM_OFS
         |=> rdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a:
      assert property (!rd_en |=> $stable(rdata))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

// *** testbench/lam_liu_model.sv ***
// Line interface stand-in driving receive clock and data.
// Assumes the bench picks a running or stopped clock and all ones or zeros.
`timescale 1ns/10ps
`default_nettype none
module lam_liu_model (
   // Control from the bench
   input wire logic run,
   input wire logic ones,
   // Line towards the monitor
   output logic rx_line_clock,
   output logic rx_data
);
   initial begin
      rx_line_clock = 1'h0;
      rx_data = 1'h1;
      #7;
      forever begin
         #80;
         if (run) begin
            rx_line_clock = ~rx_line_clock;
            // New bit on the falling edge, settled at the rising one
            if (!rx_line_clock) begin
               rx_data = ones;
            end
         end else begin
            // Stopped line must not show a stale bit
            rx_line_clock = 1'h0;
            rx_data = ~rx_data;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/lam_monitor_bench.sv ***
// Self-checking bench for the line alarm status monitor.
// Assumes lam_pkg, lam_monitor, lam_chk and lam_liu_model compiled first.
`timescale 1ns/10ps
`default_nettype none
module lam_monitor_bench;
   localparam int SIG_HOLD = 30;
   localparam int INTEG = 5;
   localparam logic [8:0] RXA = lam_pkg::RX_ALARM_OFS;
   localparam logic [8:0] TXA = lam_pkg::TX_ALARM_OFS;
   logic clk, resetn, rd_en, run, ones, tx_run;
   logic rx_line_clock, rx_data, tx_line_clock, ref_clock_1544, ref_clock_2048;
   logic rx_signaling_update_en, tx_ref_clock_in_use, tx_ais_forced;
   logic [8:0] addr;
   logic [7:0] rdata, irq_status_rx_alarms, irq_status_tx_alarms, rd;
   logic [3:0] div;
   lam_pkg::lam_cfg_t cfg;
   lam_pkg::lam_align_t align;
   lam_pkg::lam_tx_in_t tx_in;
   int error_cnt, cmp_count;

   lam_monitor #(.LOSS_HOLD_CYC(20), .SIG_HOLD_CYC(SIG_HOLD), .FRAME_INTEG_CYC(INTEG)) uut (
      .clk, .resetn, .rx_line_clock, .rx_data, .cfg, .align, .tx_in, .tx_line_clock,
      .ref_clock_1544, .ref_clock_2048, .addr, .rd_en, .rdata, .irq_status_rx_alarms,
      .irq_status_tx_alarms, .rx_signaling_update_en, .tx_ref_clock_in_use, .tx_ais_forced);
   lam_liu_model liu (.run, .ones, .rx_line_clock, .rx_data);

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // Refs of 8 and 4 clk; tx line toggles every clk while running
   always @(posedge clk) begin
      div <= div + 4'h1;
      ref_clock_1544 <= div[2];
      ref_clock_2048 <= div[1];
      if (tx_run) begin
         tx_line_clock <= div[0];
      end
   end

   // ----
   // Helpers
   // ----
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic rd_reg(input logic [8:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge clk);
      rd_en <= 1'h0;
      @(posedge clk);
      rd = rdata;
   endtask
   task automatic wait_irq(input logic [7:0] m);
      int n;
      n = 0;
      @(posedge clk);
      while ((irq_status_tx_alarms & m) !== m && n < 8) begin
         @(posedge clk);
         n++;
      end
      chk("tx irq", irq_status_tx_alarms & m, m);
      if (n >= 8) final_report();
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_idle();
      rd_reg(RXA);
      chk("rx idle", rd, 8'h00);
      rd_reg(TXA);
      chk("tx idle", rd, 8'h00);
      rd_reg(9'h049);
      chk("unmapped", rd, 8'h00);
      chk("update en", {7'h0, rx_signaling_update_en}, 8'h01);
   endtask
   task automatic t_tx();
      logic [7:0] m [3] = '{8'h02, 8'h40, 8'h80};
      for (int i = 0; i < 3; i++) begin
         tx_in <= 3'h4 >> i;
         wait_irq(m[i]);
         rd_reg(TXA);
         chk("tx bit", rd, m[i]);
         tx_in <= 3'h0;
         wait_irq(m[i]);
      end
      tx_run <= 1'h0;
      cfg.ais_clock_switch <= 1'h1;
      cyc(150);
      rd_reg(TXA);
      chk("tx clock lost", rd, 8'h08);
      chk("ais forced", {7'h0, tx_ais_forced}, 8'h01);
      chk("ref in use", {7'h0, tx_ref_clock_in_use}, 8'h01);
      cfg.ais_clock_switch <= 1'h0;
      cyc(4);
      chk("ais off", {7'h0, tx_ais_forced}, 8'h00);
      tx_run <= 1'h1;
      cyc(150);
      rd_reg(TXA);
      chk("tx clock back", rd, 8'h00);
   endtask
   task automatic t_hold();
      cfg.hold_force_on <= 1'h1;
      cyc(4);
      rd_reg(RXA);
      chk("force on", rd, 8'h01);
      chk("frozen", {7'h0, rx_signaling_update_en}, 8'h00);
      cfg.hold_force_off <= 1'h1;
      cyc(4);
      rd_reg(RXA);
      chk("force off", rd, 8'h00);
      cfg.hold_force_on <= 1'h0;
      cfg.hold_force_off <= 1'h0;
      align <= 4'h1;
      cyc(1);
      align <= 4'h0;
      cyc(10);
      rd_reg(RXA);
      chk("hold runs", rd, 8'h01);
      cyc(SIG_HOLD + 20);
      rd_reg(RXA);
      chk("hold ends", rd, 8'h00);
   endtask
   task automatic t_lof();
      cfg.e1_mode <= 1'h1;
      cfg.hold_force_off <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         align <= 4'h8 >> i;
         cyc(4);
         rd_reg(RXA);
         chk("e1 lof", rd, 8'h02);
         align <= 4'h0;
         cyc(4);
      end
      cfg.frame_loss_integration <= 1'h1;
      align <= 4'h8;
      rd_reg(RXA);
      chk("lof early", rd, 8'h00);
      cyc(INTEG + 8);
      rd_reg(RXA);
      chk("lof late", rd, 8'h02);
      align <= 4'h0;
      cyc(INTEG + 8);
      cfg.frame_loss_integration <= 1'h0;
      align <= 4'h8;
      cyc(10000);
      rd_reg(RXA);
      chk("e1 ais set", rd, 8'h12);
      align <= 4'h0;
      cyc(4);
      rd_reg(RXA);
      chk("e1 ais clear", rd, 8'h00);
      cfg.hold_force_off <= 1'h0;
   endtask
   task automatic t_rx_signal_loss(input logic e1, input int pre, input int post, input int clr);
      cfg.e1_mode <= e1;
      ones <= 1'h0;
      cyc(pre);
      rd_reg(RXA);
      chk("zeros short", rd, 8'h00);
      cyc(post);
      rd_reg(RXA);
      chk("signal lost", rd, 8'h0c);
      ones <= 1'h1;
      cyc(clr);
      rd_reg(RXA);
      chk("window open", rd, 8'h0c);
      cyc(160);
      rd_reg(RXA);
      chk("signal back", rd, 8'h00);
   endtask
   task automatic t_clk();
      cfg.combined_loss_select <= 1'h1;
      run <= 1'h0;
      cyc(100);
      rd_reg(RXA);
      chk("rx clock lost", rd, 8'h08);
      run <= 1'h1;
      cyc(100);
      rd_reg(RXA);
      chk("rx clock back", rd, 8'h00);
   endtask

   initial begin
      resetn = 1'h0;
      rd_en = 1'h0;
      addr = 9'h000;
      cfg = '0;
      align = '0;
      tx_in = '0;
      run = 1'h1;
      ones = 1'h1;
      tx_run = 1'h1;
      div = 4'h0;
      ref_clock_1544 = 1'h0;
      ref_clock_2048 = 1'h0;
      tx_line_clock = 1'h0;
      error_cnt = 0;
      cmp_count = 0;
      cyc(8);
      resetn <= 1'h1;
      // Line domain leaves reset on its own clock; let it settle first
      cyc(24);
      t_idle();
      t_tx();
      t_hold();
      t_lof();
      t_rx_signal_loss(1'h0, 576, 128, 640);
      t_rx_signal_loss(1'h1, 166, 80, 1150);
      t_clk();
      final_report();
   end
endmodule

bind lam_monitor lam_chk chk_i (.clk, .resetn, .rx_line_clock, .cfg, .align, .tx_in, .addr,
   .rd_en, .rdata, .irq_status_rx_alarms, .irq_status_tx_alarms, .rx_signaling_update_en,
   .tx_ref_clock_in_use, .tx_ais_forced);
`default_nettype wire
